/* design/avlc_pkg.sv */
package avlc_pkg;

   // ************************************************************
   // register map: printed offsets are word indices
   // ************************************************************
   localparam logic [5:0] AVLC_IDX_VOL = 6'h0F;
   localparam logic [5:0] AVLC_IDX_CTL1 = 6'h20;
   localparam logic [5:0] AVLC_IDX_CTL2 = 6'h21;
   localparam logic [5:0] AVLC_IDX_CTL3 = 6'h22;
   localparam logic [5:0] AVLC_IDX_PGA = 6'h2D;

   // field positions
   localparam int AVLC_VOL_LSB = 0;
   localparam int AVLC_MIN_LSB = 0;
   localparam int AVLC_MAX_LSB = 3;
   localparam int AVLC_EN_BIT = 8;
   localparam int AVLC_LVL_LSB = 0;
   localparam int AVLC_ATK_LSB = 0;
   localparam int AVLC_DCY_LSB = 4;
   localparam int AVLC_MODE_BIT = 8;
   localparam int AVLC_PGA_SW_LSB = 0;
   localparam int AVLC_PGA_RB_LSB = 8;

   // reset values
   localparam logic [7:0] AVLC_VOL_RST = 8'hFF;
   localparam logic AVLC_EN_RST = 1'h0;
   localparam logic [2:0] AVLC_MAX_RST = 3'h7;
   localparam logic [2:0] AVLC_MIN_RST = 3'h0;
   localparam logic [3:0] AVLC_LVL_RST = 4'hB;
   localparam logic AVLC_MODE_RST = 1'h0;
   localparam logic [3:0] AVLC_DCY_RST = 4'h3;
   localparam logic [3:0] AVLC_ATK_RST = 4'h2;
   localparam logic [5:0] AVLC_PGA_SW_RST = 6'h10;

   // pga code: 0.75 dB per step, code 0 is -12 dB
   localparam logic [5:0] AVLC_FLOOR_STEP = 6'h08;
   localparam logic [5:0] AVLC_CEIL_OFS = 6'h07;
   localparam logic [3:0] AVLC_LVL_TOP = 4'hE;
   localparam logic [3:0] AVLC_RATE_CAP = 4'hA;

   // step times in ns, and the clock period
   localparam int AVLC_CLK_NS = 10;
   localparam int AVLC_DCY_NORM_NS = 410000;
   localparam int AVLC_ATK_NORM_NS = 104000;
   localparam int AVLC_DCY_LIM_NS = 90800;
   localparam int AVLC_ATK_LIM_NS = 22700;
   localparam int AVLC_ATK_LIM_CYC = (AVLC_ATK_LIM_NS + AVLC_CLK_NS - 1) / AVLC_CLK_NS;

   // one audio sample with its strobe
   typedef struct packed {
      logic valid;
      logic signed [15:0] data;
   } avlc_sample_t;

   typedef struct packed {
      logic [7:0] vol;
      logic en;
      logic [2:0] gmax;
      logic [2:0] gmin;
      logic [3:0] lvl;
      logic mode;
      logic [3:0] dcy;
      logic [3:0] atk;
      logic [5:0] pga_sw;
   } avlc_regs_t;

   typedef struct packed {
      avlc_regs_t regs;
      logic [5:0] pga;
      logic [15:0] peak;
      logic [31:0] atk_cnt;
      logic [31:0] dcy_cnt;
      logic ack;
      logic [31:0] rdat;
      avlc_sample_t out;
   } avlc_state_t;

endpackage

/* design/avlc_vol_scale.sv */
`timescale 1ns/10ps
`default_nettype none

module avlc_vol_scale
   import avlc_pkg::*;
(
   input wire logic [7:0] code_i,           // digital gain code
   input wire logic signed [15:0] sample_i, // raw adc sample
   output logic signed [15:0] sample_o      // scaled sample
);

   logic [7:0] atten;
   logic [4:0] oct;
   logic [3:0] frac;
   logic [15:0] mant;
   logic signed [32:0] prod;
   logic signed [32:0] shifted;

   // ************************************************************
   // half-dB steps split into 6 dB octaves and a mantissa
   // ************************************************************
   // one octave is taken as a plain halving; 0.02 dB error per octave
   always_comb begin
      atten = 8'hFF - code_i;
      oct = 5'(atten / 8'd12);
      frac = 4'(atten % 8'd12);
      unique case (frac)
         4'h0: mant = 16'h8000;
         4'h1: mant = 16'h78D7;
         4'h2: mant = 16'h7215;
         4'h3: mant = 16'h6BB3;
         4'h4: mant = 16'h65AD;
         4'h5: mant = 16'h5FFD;
         4'h6: mant = 16'h5A9E;
         4'h7: mant = 16'h558C;
         4'h8: mant = 16'h50C3;
         4'h9: mant = 16'h4C3F;
         4'hA: mant = 16'h47FB;
         4'hB: mant = 16'h43F5;
         default: mant = 16'h0000;
      endcase
      prod = sample_i * $signed({1'b0, mant});
      shifted = prod >>> (6'd15 + 6'(oct));
      // code zero is a hard mute
      if (code_i == 8'h00) begin
         sample_o = 16'sh0000;
      end else begin
         sample_o = shifted[15:0]; // 0.5*(code-255) dB
      end
   end

endmodule

`default_nettype wire

/* design/avlc_adc_gain.sv */
// How it works
// - A gain code of zero mutes the recorded samples whatever comes in.
// - Codes 1 to 255 scale samples by 0.5 dB times (code - 255), -127 dB to 0 dB.
// - After reset the gain code is all ones, so samples pass at unity gain.
// - While enabled, a peak detector tracks input amplitude and compares it with the target.
// - Below the target, the pga gain steps up at the decay-rate pace.
// - Above the target, the pga gain steps down at the attack-rate pace.
// - The operating style picks normal level control or peak limiting.
// - Bit 8 of the first level register turns the controller on (1) or off (0).
// - The floor field in bits 2:0 sets the least gain, -12 dB plus 6 dB per code.
// - The ceiling field in bits 5:3 sets the most gain, -6.75 dB plus 6 dB per code.
// - The target field sets -22.5 dBFS plus 1.5 dB per code, codes 14 and 15 both -1.5 dBFS.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module avlc_adc_gain
   import avlc_pkg::*;
#(
   parameter int unsigned DCY_NORM_CYC = (AVLC_DCY_NORM_NS + AVLC_CLK_NS - 1) / AVLC_CLK_NS,
   parameter int unsigned ATK_NORM_CYC = (AVLC_ATK_NORM_NS + AVLC_CLK_NS - 1) / AVLC_CLK_NS,
   parameter int unsigned DCY_LIM_CYC = (AVLC_DCY_LIM_NS + AVLC_CLK_NS - 1) / AVLC_CLK_NS
)
(
   input wire logic clk_i,                 // 100 MHz clock
   input wire logic rst_i,                 // sync reset, high
   input wire logic wb_cyc_i,              // bus cycle
   input wire logic wb_stb_i,              // bus strobe
   input wire logic wb_we_i,               // write enable
   input wire logic [7:0] wb_adr_i,        // byte address
   input wire logic [3:0] wb_sel_i,        // byte lanes
   input wire logic [31:0] wb_dat_i,       // write data
   output logic [31:0] wb_dat_o,           // read data
   output logic wb_ack_o,                  // bus acknowledge
   input wire avlc_sample_t adc_sample_i,  // samples from adc
   output avlc_sample_t rec_sample_o,      // samples to record path
   output logic [5:0] pga_gain_o           // pga gain code
);

   avlc_state_t s_q;
   avlc_state_t s_d;

   logic signed [15:0] scaled;
   logic [5:0] idx;
   logic req;
   logic [15:0] mag;
   logic [15:0] thr;
   logic [5:0] floor_code;
   logic [5:0] ceil_code;
   logic [5:0] up_lim;
   logic [3:0] dcy_rate;
   logic [3:0] atk_rate;
   logic [31:0] dcy_per;
   logic [31:0] atk_per;
   logic dcy_tick;
   logic atk_tick;
   logic [15:0] peak_now;

   // level controller decisions
   logic out_high; // gain above the ceiling
   logic out_low; // gain below the floor
   logic too_loud; // attack step due
   logic quiet_step; // decay step allowed
   logic [5:0] pga_dn; // one code down
   logic [5:0] pga_up; // one code up

   // ************************************************************
   // target level lookup
   // ************************************************************
   // full scale is 32768; entries are 10^(dBFS/20) of it
   function automatic logic [15:0] lvl_thr(input logic [3:0] code);
      logic [3:0] c;
      c = (code > AVLC_LVL_TOP) ? AVLC_LVL_TOP : code; // 14 and 15 alike
      unique case (c)
         4'h0: lvl_thr = 16'h0999;
         4'h1: lvl_thr = 16'h0B68;
         4'h2: lvl_thr = 16'h0D8F;
         4'h3: lvl_thr = 16'h101D;
         4'h4: lvl_thr = 16'h1327;
         4'h5: lvl_thr = 16'h16C3;
         4'h6: lvl_thr = 16'h1B0D;
         4'h7: lvl_thr = 16'h2027;
         4'h8: lvl_thr = 16'h2637;
         4'h9: lvl_thr = 16'h2D6B;
         4'hA: lvl_thr = 16'h35FA;
         4'hB: lvl_thr = 16'h4027;
         4'hC: lvl_thr = 16'h4C3F;
         4'hD: lvl_thr = 16'h5A9E;
         default: lvl_thr = 16'h6BB3;
      endcase
   endfunction

   // ************************************************************
   // digital volume stage
   // ************************************************************
   // combinational; its result is registered with the sample strobe
   avlc_vol_scale u_scale (
      .code_i(s_q.regs.vol),
      .sample_i(adc_sample_i.data),
      .sample_o(scaled)
   );

   // ************************************************************
   // level controller helpers
   // ************************************************************
   // limits and pace derived from the control fields
   always_comb begin
      floor_code = AVLC_FLOOR_STEP * {3'h0, s_q.regs.gmin};
      ceil_code = AVLC_FLOOR_STEP * {3'h0, s_q.regs.gmax} + AVLC_CEIL_OFS;
      // the limiter only gives back gain up to the software setting
      if (s_q.regs.mode && (s_q.regs.pga_sw < ceil_code)) begin
         up_lim = s_q.regs.pga_sw;
      end else begin
         up_lim = ceil_code;
      end
      // codes above ten keep the slowest pace
      dcy_rate = (s_q.regs.dcy > AVLC_RATE_CAP) ? AVLC_RATE_CAP : s_q.regs.dcy;
      atk_rate = (s_q.regs.atk > AVLC_RATE_CAP) ? AVLC_RATE_CAP : s_q.regs.atk;
      // each code doubles the step time
      if (s_q.regs.mode) begin
         dcy_per = DCY_LIM_CYC << dcy_rate;
         atk_per = AVLC_ATK_LIM_CYC << atk_rate;
      end else begin
         dcy_per = DCY_NORM_CYC << dcy_rate;
         atk_per = ATK_NORM_CYC << atk_rate;
      end
      thr = lvl_thr(s_q.regs.lvl);
   end

   // absolute value of the incoming sample, saturating -32768
   always_comb begin
      if (adc_sample_i.data[15]) begin
         mag = 16'(-adc_sample_i.data);
         // negating -32768 gives -32768 again
         if (mag[15]) begin
            mag = 16'h7FFF;
         end
      end else begin
         mag = adc_sample_i.data;
      end
   end

   // peak including the sample in this cycle
   always_comb begin
      if (adc_sample_i.valid && (mag > s_q.peak)) begin
         peak_now = mag;
      end else begin
         peak_now = s_q.peak;
      end
   end

   // pace pulses: one-cycle enables off the main clock, no second clock domain
   assign dcy_tick = (s_q.dcy_cnt + 32'h1) >= dcy_per;
   assign atk_tick = (s_q.atk_cnt + 32'h1) >= atk_per;

   // ************************************************************
   // level controller decisions
   // ************************************************************
   // a window that held a loud peak never earns a decay step
   always_comb begin
      out_high = s_q.pga > ceil_code;
      out_low = s_q.pga < floor_code;
      too_loud = atk_tick && (peak_now > thr);
      quiet_step = dcy_tick && (peak_now < thr) && (s_q.pga < up_lim);
      pga_dn = s_q.pga - 6'h01;
      pga_up = s_q.pga + 6'h01;
   end

   // ************************************************************
   // bus decode
   // ************************************************************
   // ack still high blocks a second take of a request held one cycle on
   assign idx = wb_adr_i[7:2];
   assign req = wb_cyc_i && wb_stb_i && !s_q.ack;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d = s_q;
      s_d.ack = req; // one-cycle answer, dropped the cycle after
      s_d.rdat = 32'h0000_0000;

      // ************************************************************
      // register writes
      // ************************************************************
      // register writes take place on the acknowledging edge
      if (req && wb_we_i) begin
         unique case (idx)
            AVLC_IDX_VOL: begin
               if (wb_sel_i[0]) begin
                  s_d.regs.vol = wb_dat_i[AVLC_VOL_LSB +: 8];
               end
            end
            AVLC_IDX_CTL1: begin
               if (wb_sel_i[0]) begin
                  s_d.regs.gmin = wb_dat_i[AVLC_MIN_LSB +: 3];
                  s_d.regs.gmax = wb_dat_i[AVLC_MAX_LSB +: 3];
               end
               if (wb_sel_i[1]) begin
                  s_d.regs.en = wb_dat_i[AVLC_EN_BIT];
               end
            end
            AVLC_IDX_CTL2: begin
               if (wb_sel_i[0]) begin
                  s_d.regs.lvl = wb_dat_i[AVLC_LVL_LSB +: 4];
               end
            end
            AVLC_IDX_CTL3: begin
               if (wb_sel_i[0]) begin
                  s_d.regs.atk = wb_dat_i[AVLC_ATK_LSB +: 4];
                  s_d.regs.dcy = wb_dat_i[AVLC_DCY_LSB +: 4];
               end
               if (wb_sel_i[1]) begin
                  s_d.regs.mode = wb_dat_i[AVLC_MODE_BIT];
               end
            end
            AVLC_IDX_PGA: begin
               if (wb_sel_i[0]) begin
                  s_d.regs.pga_sw = wb_dat_i[AVLC_PGA_SW_LSB +: 6];
               end
            end
            default: begin
               // unmapped: acknowledged, nothing stored
            end
         endcase
      end

      // ************************************************************
      // register reads
      // ************************************************************
      // read data, reserved bits zero, unmapped reads zero
      if (req && !wb_we_i) begin
         unique case (idx)
            AVLC_IDX_VOL: begin
               s_d.rdat[AVLC_VOL_LSB +: 8] = s_q.regs.vol;
            end
            AVLC_IDX_CTL1: begin
               s_d.rdat[AVLC_MIN_LSB +: 3] = s_q.regs.gmin;
               s_d.rdat[AVLC_MAX_LSB +: 3] = s_q.regs.gmax;
               s_d.rdat[AVLC_EN_BIT] = s_q.regs.en;
            end
            AVLC_IDX_CTL2: begin
               s_d.rdat[AVLC_LVL_LSB +: 4] = s_q.regs.lvl;
            end
            AVLC_IDX_CTL3: begin
               s_d.rdat[AVLC_ATK_LSB +: 4] = s_q.regs.atk;
               s_d.rdat[AVLC_DCY_LSB +: 4] = s_q.regs.dcy;
               s_d.rdat[AVLC_MODE_BIT] = s_q.regs.mode;
            end
            AVLC_IDX_PGA: begin
               // live gain readback shows what the controller chose
               s_d.rdat[AVLC_PGA_SW_LSB +: 6] = s_q.regs.pga_sw;
               s_d.rdat[AVLC_PGA_RB_LSB +: 6] = s_q.pga;
            end
            default: begin
               s_d.rdat = 32'h0000_0000;
            end
         endcase
      end

      // ************************************************************
      // sample path
      // ************************************************************
      // volume stage output, one cycle behind the input
      s_d.out.valid = adc_sample_i.valid;
      if (adc_sample_i.valid) begin
         s_d.out.data = scaled;
      end

      // ************************************************************
      // level controller
      // ************************************************************
      // one step per cycle at most while enabled, so the gain never jumps
      if (!s_q.regs.en) begin
         // software owns the gain; timers and detector idle
         s_d.pga = s_q.regs.pga_sw;
         s_d.peak = 16'h0000;
         s_d.atk_cnt = 32'h0000_0000;
         s_d.dcy_cnt = 32'h0000_0000;
      end else begin
         s_d.peak = peak_now;
         s_d.atk_cnt = atk_tick ? 32'h0000_0000 : s_q.atk_cnt + 32'h1;
         s_d.dcy_cnt = dcy_tick ? 32'h0000_0000 : s_q.dcy_cnt + 32'h1;
         // a floor above the ceiling makes the gain hunt between the ceiling and one code above it
         if (out_high) begin
            // limits moved under us: pull back in one step per cycle
            s_d.pga = pga_dn;
         end else if (out_low) begin
            s_d.pga = pga_up;
         end else if (too_loud) begin
            // too loud: back off, then start a fresh peak window
            if (s_q.pga > floor_code) begin
               s_d.pga = pga_dn;
            end
            s_d.peak = 16'h0000;
            s_d.dcy_cnt = 32'h0000_0000;
         end else if (dcy_tick) begin
            // quiet over a whole decay period: give back one step
            if (quiet_step) begin
               s_d.pga = pga_up;
            end
            s_d.peak = 16'h0000;
         end
      end

      // ************************************************************
      // reset values
      // ************************************************************
      // synchronous reset overrides every update above
      if (rst_i) begin
         s_d.regs.vol = AVLC_VOL_RST;
         s_d.regs.en = AVLC_EN_RST;
         s_d.regs.gmax = AVLC_MAX_RST;
         s_d.regs.gmin = AVLC_MIN_RST;
         s_d.regs.lvl = AVLC_LVL_RST;
         s_d.regs.mode = AVLC_MODE_RST;
         s_d.regs.dcy = AVLC_DCY_RST;
         s_d.regs.atk = AVLC_ATK_RST;
         s_d.regs.pga_sw = AVLC_PGA_SW_RST;
         s_d.pga = AVLC_PGA_SW_RST;
         s_d.peak = 16'h0000;
         s_d.atk_cnt = 32'h0000_0000;
         s_d.dcy_cnt = 32'h0000_0000;
         s_d.ack = 1'b0;
         s_d.rdat = 32'h0000_0000;
         s_d.out = '0;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   // reset lives in the next-state logic, so this is one plain register
   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   // outputs straight from flip-flops
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign rec_sample_o = s_q.out;
   assign pga_gain_o = s_q.pga;

endmodule

`default_nettype wire

/* verif/avlc_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module avlc_adc_model
   import avlc_pkg::*;
(
   input wire logic clk_i,         // clock
   input wire logic rst_i,         // reset
   input wire logic on_i,          // stream on
   input wire logic [15:0] amp_i,  // peak size
   output var avlc_sample_t smp_o  // samples
);
   logic neg_q;
   // square wave of the set peak, one sample a cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_o <= '0;
         neg_q <= 1'b0;
      end else if (on_i) begin
         smp_o.valid <= 1'b1;
         smp_o.data <= neg_q ? -amp_i : amp_i;
         neg_q <= ~neg_q;
      end else begin
         // idle data inverted every cycle, never a stale copy
         smp_o.valid <= 1'b0;
         smp_o.data <= ~smp_o.data;
      end
   end
endmodule
`default_nettype wire

/* verif/avlc_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module avlc_assertions
   import avlc_pkg::*;
(
   input wire logic clk_i,                // clock
   input wire logic rst_i,                // reset
   input wire logic wb_cyc_i,             // cycle
   input wire logic wb_stb_i,             // strobe
   input wire logic wb_we_i,              // write
   input wire logic [7:0] wb_adr_i,       // address
   input wire logic [3:0] wb_sel_i,       // lanes
   input wire logic [31:0] wb_dat_i,      // write data
   input wire logic [31:0] wb_dat_o,      // read data
   input wire logic wb_ack_o,             // ack
   input wire avlc_sample_t adc_sample_i, // samples in
   input wire avlc_sample_t rec_sample_o, // samples out
   input wire logic [5:0] pga_gain_o      // pga code
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] vol_q;
   logic en_q;
   logic wr;
   assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
   // mirror of gain code and enable, so output checks know the mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vol_q <= 8'hFF;
         en_q <= 1'h0;
      end else if (wr && wb_adr_i == 8'h3C && wb_sel_i[0]) begin
         vol_q <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i == 8'h80 && wb_sel_i[1]) begin
         en_q <= wb_dat_i[8];
      end
   end
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence smp_s;
      adc_sample_i.valid;
   endsequence
   ack_resp_a: assert property (take_s |=> wb_ack_o) else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   rec_valid_a: assert property (smp_s |=> rec_sample_o.valid) else $error("sample lost");
   rec_idle_a: assert property (!adc_sample_i.valid |=> !rec_sample_o.valid) else $error("extra sample");
   mute_out_a: assert property (smp_s ##0 vol_q == 8'h00 |=> rec_sample_o.data == 16'h0000)
      else $error("muted path not silent");
   unity_gain_a: assert property (smp_s ##0 vol_q == 8'hFF |=> rec_sample_o.data == $past(adc_sample_i.data))
      else $error("full code not unity");
   pga_step_a: assert property (en_q && $past(en_q) |-> 6'(pga_gain_o - $past(pga_gain_o)) inside {6'h00, 6'h01, 6'h3F})
      else $error("pga jumped");
   rst_vals_a: assert property ($fell(rst_i) |-> pga_gain_o == 6'h10 && !wb_ack_o) else $error("bad reset outputs");
endmodule
bind avlc_adc_gain avlc_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .adc_sample_i(adc_sample_i), .rec_sample_o(rec_sample_o), .pga_gain_o(pga_gain_o));
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import avlc_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, on;
   logic [7:0] wb_adr_i, cur_vol;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] amp;
   logic [5:0] pga_gain_o;
   avlc_sample_t adc_s, rec_s;
   logic [31:0] rq[$];
   logic [15:0] sq[$];
   int err_total, samples_checked;
   // ******
   // clock, design and converter model
   // ******
   always #5 clk_i = ~clk_i;
   // short step periods keep the level loop within a few hundred cycles
   avlc_adc_gain #(.DCY_NORM_CYC(40), .ATK_NORM_CYC(10), .DCY_LIM_CYC(9)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_sample_i(adc_s),
      .rec_sample_o(rec_s), .pga_gain_o(pga_gain_o));
   avlc_adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .on_i(on), .amp_i(amp), .smp_o(adc_s));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // whole 6 dB steps are exact halvings, truncated toward minus infinity
   function automatic logic [15:0] exp_s(input logic [7:0] c, input logic signed [15:0] x);
      logic signed [31:0] w;
      w = x;
      if (c == 8'h00) return 16'h0000;
      w = w >>> ((8'hFF - c) / 12);
      return w[15:0];
   endfunction
   // ******
   // result watcher: oldest note against each answer
   // ******
   always @(posedge clk_i) begin
      if (!rst_i && wb_ack_o === 1'b1 && !wb_we_i) begin
         chk("read data", wb_dat_o, rq.pop_front());
      end
      if (rec_s.valid === 1'b1) begin
         chk("sample", {16'h0, rec_s.data}, {16'h0, sq.pop_front()});
      end
      if (adc_s.valid === 1'b1) begin
         sq.push_back(exp_s(cur_vol, adc_s.data));
      end
   end
   task automatic run(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'h3;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         $display("Error bus ack expected 1 seen 0");
         test_done();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wbx(1'b0, a, 32'h0);
   endtask
   // ******
   // main sequence
   // ******
   initial begin
      logic [7:0] v;
      int s;
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, on} = 4'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h3;
      wb_dat_i = 32'h0;
      amp = 16'h0000;
      cur_vol = 8'hFF;
      err_total = 0;
      samples_checked = 0;
      s = $urandom(65898);
      run(16);
      rst_i <= 1'b0;
      run(1);
      rd(8'h3C, 32'h0FF);
      rd(8'h80, 32'h038);
      rd(8'h84, 32'h00B);
      wbx(1'b1, 8'hFC, 32'h1FF);
      rd(8'hFC, 32'h0);
      $display("test defaults done");
      // each 6 dB code, then mute; stream off while the code changes
      for (int k = 0; k <= 22; k++) begin
         v = (k == 22) ? 8'h00 : 8'(255 - 12 * k);
         wbx(1'b1, 8'h3C, {24'h0, v});
         cur_vol = v;
         amp <= 16'($urandom);
         on <= 1'b1;
         run(4);
         on <= 1'b0;
         run(3);
      end
      $display("test gain codes done");
      // quiet input under the lowest target climbs to the ceiling
      wbx(1'b1, 8'h88, 32'h000);
      wbx(1'b1, 8'h84, 32'h000);
      wbx(1'b1, 8'h80, 32'h111);
      amp <= 16'h0900;
      on <= 1'b1;
      run(600);
      rd(8'hB4, 32'h1710);
      amp <= 16'h0A00;
      run(300);
      rd(8'hB4, 32'h0810);
      $display("test level loop done");
      // limiter climbs back only to the software gain; with the controller off the gain is the software gain
      wbx(1'b1, 8'hB4, 32'h00C);
      wbx(1'b1, 8'h88, 32'h100);
      amp <= 16'h0900;
      run(300);
      rd(8'hB4, 32'h0C0C);
      wbx(1'b1, 8'hB4, 32'h014);
      wbx(1'b1, 8'h80, 32'h011);
      run(200);
      rd(8'hB4, 32'h1414);
      // highest floor holds a loud input at code 56
      wbx(1'b1, 8'h88, 32'h000);
      wbx(1'b1, 8'h80, 32'h1FF);
      amp <= 16'h7FFF;
      run(200);
      rd(8'hB4, 32'h3814);
      // limiter attack: one step down per limiter attack period
      wbx(1'b1, 8'h88, 32'h100);
      wbx(1'b1, 8'h80, 32'h138);
      run(AVLC_ATK_LIM_CYC + 200);
      rd(8'hB4, 32'h3714);
      on <= 1'b0;
      run(4);
      // reset in mid-run brings back the defaults
      rst_i <= 1'b1;
      run(2);
      rst_i <= 1'b0;
      run(1);
      rd(8'h3C, 32'h0FF);
      rd(8'hB4, 32'h1010);
      chk("pending samples", 32'(sq.size()), 32'h0);
      $display("test limits done");
      test_done();
   end
endmodule
`default_nettype wire
